// ---- serp_top.sv ----
// Two-wire serial memory target: acknowledge polling and read modes
`timescale 1ns/10ps
module serp_top
    import serp_pkg::*;
#(
    parameter int unsigned WR_CYCLES_P = WR_CYCLES
) (
    // Clock and reset
    input  wire logic CORE_CLK_I,
    input  wire logic RESETN_I,
    // Two-wire bus
    input  wire logic SCL_I,
    input  wire logic SDA_I,
    output logic      SDA_O,
    output logic      SDA_OE_O,
    // Strap and status
    input  wire logic CHIP_SELECT_STRAP_I,
    output logic      PROG_BUSY_O
);

    // Synchroniser stages and previous sampled value
    serp_line_t  line_s1_reg;
    serp_line_t  line_s2_reg;
    serp_line_t  line_d_reg;
    logic        strap_s1_reg;
    logic        strap_s2_reg;

    // Protocol state
    serp_state_t        state_reg,    state_next;
    serp_kind_t         kind_reg,     kind_next;
    logic [3:0]         bit_reg,      bit_next;
    logic [7:0]         shift_reg,    shift_next;
    logic [7:0]         tx_reg,       tx_next;
    logic               rw_reg,       rw_next;
    logic [AHI_USED_W-1:0] ahi_reg,   ahi_next;
    logic [ADDR_W-1:0]  addr_reg,     addr_next;
    logic               oe_reg,       oe_next;
    logic               sda_o_reg;
    logic               mack_reg,     mack_next;
    logic               pend_reg,     pend_next;
    logic [ADDR_W-1:0]  pend_addr_reg, pend_addr_next;
    logic [7:0]         pend_data_reg, pend_data_next;
    logic               busy_reg,     busy_next;
    logic [WR_CNT_W-1:0] wr_cnt_reg,  wr_cnt_next;

    // Array and helpers
    logic [7:0] mem [MEM_DEPTH];
    logic       mem_we;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;
    logic       load_tx;
    logic [7:0] rd_byte;

    // Counter advance with explicit wrap at the top of the array
    function automatic logic [ADDR_W-1:0] addr_inc(
        input logic [ADDR_W-1:0] a
    );
        if (a == ADDR_MAX) begin
            return ADDR_FIRST;
        end
        return a + ADDR_STEP;
    endfunction : addr_inc

    // Bus events seen through the synchroniser
    assign scl_rise = line_s2_reg.scl & ~line_d_reg.scl;
    assign scl_fall = ~line_s2_reg.scl & line_d_reg.scl;
    assign start_ev = line_s2_reg.scl & line_d_reg.scl
                    & line_d_reg.sda & ~line_s2_reg.sda;
    assign stop_ev  = line_s2_reg.scl & line_d_reg.scl
                    & ~line_d_reg.sda & line_s2_reg.sda;
    assign rd_byte  = mem[addr_reg];

    // Next-state logic for the link and programming timer
    always_comb begin
        state_next     = state_reg;
        kind_next      = kind_reg;
        bit_next       = bit_reg;
        shift_next     = shift_reg;
        tx_next        = tx_reg;
        rw_next        = rw_reg;
        ahi_next       = ahi_reg;
        addr_next      = addr_reg;
        oe_next        = oe_reg;
        mack_next      = mack_reg;
        pend_next      = pend_reg;
        pend_addr_next = pend_addr_reg;
        pend_data_next = pend_data_reg;
        busy_next      = busy_reg;
        wr_cnt_next    = wr_cnt_reg;
        mem_we         = 1'b0;
        load_tx        = 1'b0;
        // Programming timer
        if (busy_reg) begin
            wr_cnt_next = wr_cnt_reg - WR_CNT_W'(1);
            if (wr_cnt_reg == WR_CNT_W'(1)) begin
                busy_next = 1'b0;
            end
        end
        if (start_ev) begin
            state_next = S_RX;
            kind_next  = K_DEV;
            bit_next   = BIT_NONE;
            oe_next    = 1'b0;
            pend_next  = 1'b0;
        end else if (stop_ev) begin
            state_next = S_IDLE;
            oe_next    = 1'b0;
            pend_next  = 1'b0;
            if (pend_reg) begin
                mem_we      = 1'b1;
                busy_next   = 1'b1;
                wr_cnt_next = WR_CNT_W'(WR_CYCLES_P);
            end
        end else begin
            unique case (state_reg)
                S_IDLE: begin
                end
                S_RX: begin
                    if (scl_rise && bit_reg != BIT_BYTE) begin
                        shift_next = {shift_reg[6:0], line_s2_reg.sda};
                        bit_next   = bit_reg + BIT_ONE;
                    end else if (scl_fall && bit_reg == BIT_BYTE) begin
                        state_next = S_RX_ACK;
                        oe_next    = 1'b1;
                        unique case (kind_reg)
                            K_DEV: begin
                                rw_next = shift_reg[DEV_RW_BIT];
                                if (shift_reg[DEV_CODE_HI:DEV_CODE_LO]
                                        != DEV_CODE
                                    || shift_reg[DEV_CS_BIT]
                                        != strap_s2_reg) begin
                                    state_next = S_IDLE;
                                    oe_next    = 1'b0;
                                end else if (busy_reg) begin
                                    state_next = S_IDLE;
                                    oe_next    = 1'b0;
                                end
                            end
                            K_AHI: ahi_next = shift_reg[AHI_USED_W-1:0];
                            K_ALO: addr_next = {ahi_reg, shift_reg};
                            K_DATA: begin
                                pend_next      = 1'b1;
                                pend_addr_next = addr_reg;
                                pend_data_next = shift_reg;
                                addr_next      = addr_inc(addr_reg);
                            end
                        endcase
                    end
                end
                S_RX_ACK: begin
                    if (scl_fall) begin
                        oe_next  = 1'b0;
                        bit_next = BIT_NONE;
                        state_next = S_RX;
                        unique case (kind_reg)
                            K_DEV: begin
                                if (rw_reg) begin
                                    load_tx = 1'b1;
                                end else begin
                                    kind_next = K_AHI;
                                end
                            end
                            K_AHI:  kind_next = K_ALO;
                            K_ALO:  kind_next = K_DATA;
                            K_DATA: kind_next = K_DATA;
                        endcase
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (bit_reg == BIT_BYTE) begin
                            oe_next    = 1'b0;
                            state_next = S_TX_ACK;
                        end else begin
                            oe_next  = ~tx_reg[7];
                            tx_next  = {tx_reg[6:0], 1'b0};
                            bit_next = bit_reg + BIT_ONE;
                        end
                    end
                end
                S_TX_ACK: begin
                    if (scl_rise) begin
                        mack_next = ~line_s2_reg.sda;
                    end else if (scl_fall) begin
                        if (mack_reg) begin
                            load_tx = 1'b1;
                        end else begin
                            state_next = S_IDLE;
                        end
                    end
                end
                default: state_next = S_IDLE;
            endcase
        end
        // Start shifting a byte from the counter address
        if (load_tx) begin
            state_next = S_TX;
            oe_next    = ~rd_byte[7];
            tx_next    = {rd_byte[6:0], 1'b0};
            bit_next   = BIT_ONE;
            mack_next  = 1'b0;
            addr_next  = addr_inc(addr_reg);
        end
    end

    // Synchronisers and state registers
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            line_s1_reg   <= '1;
            line_s2_reg   <= '1;
            line_d_reg    <= '1;
            strap_s1_reg  <= 1'b0;
            strap_s2_reg  <= 1'b0;
            state_reg     <= S_IDLE;
            kind_reg      <= K_DEV;
            bit_reg       <= BIT_NONE;
            shift_reg     <= '0;
            tx_reg        <= '0;
            rw_reg        <= 1'b0;
            ahi_reg       <= '0;
            addr_reg      <= ADDR_FIRST;
            oe_reg        <= 1'b0;
            sda_o_reg     <= 1'b0;
            mack_reg      <= 1'b0;
            pend_reg      <= 1'b0;
            pend_addr_reg <= ADDR_FIRST;
            pend_data_reg <= '0;
            busy_reg      <= 1'b0;
            wr_cnt_reg    <= '0;
        end else begin
            line_s1_reg   <= '{scl: SCL_I, sda: SDA_I};
            line_s2_reg   <= line_s1_reg;
            line_d_reg    <= line_s2_reg;
            strap_s1_reg  <= CHIP_SELECT_STRAP_I;
            strap_s2_reg  <= strap_s1_reg;
            state_reg     <= state_next;
            kind_reg      <= kind_next;
            bit_reg       <= bit_next;
            shift_reg     <= shift_next;
            tx_reg        <= tx_next;
            rw_reg        <= rw_next;
            ahi_reg       <= ahi_next;
            addr_reg      <= addr_next;
            oe_reg        <= oe_next;
            sda_o_reg     <= 1'b0; // Only ever pulls low
            mack_reg      <= mack_next;
            pend_reg      <= pend_next;
            pend_addr_reg <= pend_addr_next;
            pend_data_reg <= pend_data_next;
            busy_reg      <= busy_next;
            wr_cnt_reg    <= wr_cnt_next;
        end
    end

    // Array write at the end of a write command
    always_ff @(posedge CORE_CLK_I) begin
        if (mem_we) begin
            mem[pend_addr_reg] <= pend_data_reg;
        end
    end

    // Outputs
    assign SDA_O       = sda_o_reg;
    assign SDA_OE_O    = oe_reg;
    assign PROG_BUSY_O = busy_reg;

endmodule : serp_top

// ---- serp_pkg.sv ----
// Shared constants and types for the serial memory read and poll target
package serp_pkg;
    // Array geometry
    localparam int         ADDR_W     = 10;
    localparam int         MEM_DEPTH  = 1024;
    localparam logic [9:0] ADDR_FIRST = 10'h000;
    localparam logic [9:0] ADDR_MAX   = 10'h3ff;
    localparam logic [9:0] ADDR_STEP  = 10'h001;

    // Device address byte layout
    localparam logic [3:0] DEV_CODE    = 4'ha;
    localparam int         DEV_CODE_HI = 7;
    localparam int         DEV_CODE_LO = 4;
    localparam int         DEV_CS_BIT  = 3;
    localparam int         DEV_RW_BIT  = 0;
    localparam int         AHI_USED_W  = 2;

    // Bit counting
    localparam logic [3:0] BIT_NONE  = 4'h0;
    localparam logic [3:0] BIT_ONE   = 4'h1;
    localparam logic [3:0] BIT_BYTE  = 4'h8;

    // Self-timed programming time
    localparam int T_WR_NS       = 5000000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int WR_CYCLES     = T_WR_NS / CLK_PERIOD_NS;
    localparam int WR_CNT_W      = 20;

    // Sampled bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } serp_line_t;

    // Link state
    typedef enum logic [2:0] {
        S_IDLE,
        S_RX,
        S_RX_ACK,
        S_TX,
        S_TX_ACK
    } serp_state_t;

    // Meaning of the byte being received
    typedef enum logic [1:0] {
        K_DEV,
        K_AHI,
        K_ALO,
        K_DATA
    } serp_kind_t;
endpackage : serp_pkg

// ---- serp_top_asserts.sv ----
// Port checker for the serial memory read and poll target
`timescale 1ns/10ps
module serp_top_asserts #(
    parameter int unsigned WR_CYCLES_P = 200
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    // Bus, strap and status
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    input wire logic CHIP_SELECT_STRAP_I,
    input wire logic PROG_BUSY_O
);
    logic [31:0] busy_cnt_reg;
    logic [31:0] busy_cnt_next;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);
    // Length of the running programming cycle
    always_comb busy_cnt_next = PROG_BUSY_O ? busy_cnt_reg + 1 : '0;
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) busy_cnt_reg <= '0;
        else busy_cnt_reg <= busy_cnt_next;
    end
    a_low_drive_only: assert property (SDA_OE_O |-> !SDA_O)
        else $error("data line driven high");
    a_drive_on_low: assert property ($changed(SDA_OE_O) |-> !SCL_I)
        else $error("drive changed while clock high");
    a_drive_stands: assert property ($rose(SDA_OE_O) |=> SDA_OE_O[*8])
        else $error("drive released too early");
    a_busy_no_ack: assert property (PROG_BUSY_O |-> !SDA_OE_O)
        else $error("drive while programming");
    a_busy_holds: assert property ($rose(PROG_BUSY_O) |=> PROG_BUSY_O[*8])
        else $error("programming ended at once");
    a_busy_bounded: assert property (PROG_BUSY_O |->
        busy_cnt_reg <= WR_CYCLES_P) else $error("programming too long");
    a_busy_on_stop: assert property ($rose(PROG_BUSY_O) |-> SCL_I && SDA_I)
        else $error("programming began without stop");
    a_reset_quiet: assert property ($rose(RESETN_I) |->
        !SDA_OE_O && !PROG_BUSY_O) else $error("outputs busy after reset");
endmodule : serp_top_asserts

bind serp_top serp_top_asserts #(.WR_CYCLES_P(WR_CYCLES_P)) serp_chk_inst (
    .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .SCL_I(SCL_I),
    .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
    .CHIP_SELECT_STRAP_I(CHIP_SELECT_STRAP_I), .PROG_BUSY_O(PROG_BUSY_O));

// ---- serp_ctrl.sv ----
// Behavioural two-wire bus controller facing the memory target
`timescale 1ns/10ps
module serp_ctrl #(
    // Quarter bit time, giving a 48 ns bus clock period
    parameter int Q_NS = 12
) (
    // Bus drive
    output logic      scl_o,
    output logic      sda_oe_o,
    // Resolved data wire
    input  wire logic sda_i
);
    // Idle bus, clock stands high
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // One pulse, data set in low phase, wire sampled in high phase
    task automatic clk_bit(input logic b, output logic s);
        sda_oe_o = !b;
        #(Q_NS);
        scl_o = 1'b1;
        #(Q_NS);
        s = sda_i;
        #(Q_NS);
        scl_o = 1'b0;
        #(Q_NS);
    endtask : clk_bit
    task automatic start();
        sda_oe_o = 1'b0;
        #(Q_NS);
        scl_o = 1'b1;
        #(Q_NS);
        sda_oe_o = 1'b1;
        #(2*Q_NS);
        scl_o = 1'b0;
        #(Q_NS);
    endtask : start
    task automatic stop();
        sda_oe_o = 1'b1;
        #(Q_NS);
        scl_o = 1'b1;
        #(Q_NS);
        sda_oe_o = 1'b0;
        #(2*Q_NS);
    endtask : stop
    // Sends n bits most significant first, then takes the ack slot only when n is 8
    task automatic send(input logic [7:0] d, input int n, output logic ack);
        logic s;
        for (int i = 0; i < n; i++) clk_bit(d[7-i], s);
        ack = 1'b1;
        if (n == 8) clk_bit(1'b1, ack);
    endtask : send
    // Takes a byte, then acks (low) or leaves the slot high
    task automatic recv(output logic [7:0] d, input logic nack);
        logic s;
        for (int i = 0; i < 8; i++) clk_bit(1'b1, d[7-i]);
        clk_bit(nack, s);
    endtask : recv
endmodule : serp_ctrl

// ---- serial_eeprom_read_and_poll_test.sv ----
// Self-checking bench for the serial memory read and poll target
`timescale 1ns/10ps
module serial_eeprom_read_and_poll_test import serp_pkg::*;;
    localparam int         WR_N  = 400;
    localparam logic [7:0] DEV_W = {DEV_CODE, 4'h8};
    localparam logic [7:0] DEV_R = {DEV_CODE, 4'h9};
    logic       clk;
    logic       rst_n;
    logic       strap;
    logic       scl;
    logic       ctl_oe;
    logic       sda_o;
    logic       sda_oe;
    logic       busy;
    logic       ack;
    logic [7:0] rd;
    wire logic  sda;
    int         fail_count;
    int         check_count;
    // Open-drain wire with pull-up
    assign sda = (sda_oe ? sda_o : 1'b1) && !ctl_oe;
    serp_top #(.WR_CYCLES_P(WR_N)) serp_top_inst (.CORE_CLK_I(clk),
        .RESETN_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE_O(sda_oe), .CHIP_SELECT_STRAP_I(strap), .PROG_BUSY_O(busy));
    serp_ctrl serp_ctrl_inst (.scl_o(scl), .sda_oe_o(ctl_oe), .sda_i(sda));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic st();
        serp_ctrl_inst.start();
    endtask : st
    task automatic sp();
        serp_ctrl_inst.stop();
    endtask : sp
    task automatic tx(input logic [7:0] d, input logic exp);
        serp_ctrl_inst.send(d, 8, ack);
        chk({7'h00, ack}, {7'h00, exp});
    endtask : tx
    task automatic rx(input logic [7:0] exp, input logic nack);
        serp_ctrl_inst.recv(rd, nack);
        chk(rd, exp);
    endtask : rx
    // Dummy write of a word address
    task automatic load(input logic [9:0] a);
        st();
        tx(DEV_W, 1'b0);
        tx({6'h00, a[9:8]}, 1'b0);
        tx(a[7:0], 1'b0);
    endtask : load
    task automatic t_write_poll(input logic [9:0] a, input logic [7:0] d);
        int n;
        load(a);
        tx(d, 1'b0);
        sp();
        chk({7'h00, busy}, 8'h01);
        st();
        tx(DEV_W, 1'b1);
        sp();
        for (n = 0; busy === 1'b1 && n < 2 * WR_N; n++) @(posedge clk);
        #1.2;
        chk({7'h00, busy}, 8'h00);
        load(a);
        st();
        tx(DEV_R, 1'b0);
        rx(d, 1'b1);
        sp();
        $display("write and poll done");
    endtask : t_write_poll
    task automatic t_random_wrap();
        load(10'h3ff);
        st();
        tx(DEV_R, 1'b0);
        rx(8'h5a, 1'b0);
        rx(8'hc3, 1'b1);
        sp();
        $display("random wrap done");
    endtask : t_random_wrap
    task automatic t_current();
        load(10'h3ff);
        sp();
        st();
        tx(DEV_R, 1'b0);
        rx(8'h5a, 1'b1);
        sp();
        st();
        tx(DEV_R, 1'b0);
        rx(8'hc3, 1'b1);
        sp();
        $display("current read done");
    endtask : t_current
    task automatic t_refuse();
        logic [7:0] bad [3] = '{8'h99, 8'ha1, 8'he9};
        foreach (bad[i]) begin
            st();
            tx(bad[i], 1'b1);
            sp();
        end
        strap = 1'b0;
        st();
        tx(8'ha0, 1'b0);
        sp();
        strap = 1'b1;
        $display("refuse done");
    endtask : t_refuse
    // Start in mid-byte must leave the counter where it was
    task automatic t_abort();
        load(10'h2ff);
        sp();
        load(10'h000);
        st();
        tx(DEV_W, 1'b0);
        tx(8'h03, 1'b0);
        serp_ctrl_inst.send(8'hff, 4, ack);
        st();
        tx(DEV_R, 1'b0);
        rx(8'hc3, 1'b1);
        sp();
        $display("abort done");
    endtask : t_abort
    // Reset, then the scenarios in turn
    initial begin
        rst_n = 1'b0;
        strap = 1'b1;
        fail_count = 0;
        check_count = 0;
        repeat (6) @(posedge clk);
        #1.2 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1.2;
        t_write_poll(10'h3ff, 8'h5a);
        t_write_poll(10'h000, 8'hc3);
        t_random_wrap();
        t_current();
        t_refuse();
        t_abort();
        finish_test();
    end
    // Watchdog
    initial begin
        #100us;
        fail_count++;
        finish_test();
    end
endmodule : serial_eeprom_read_and_poll_test
